// >>> fanp_pkg.sv
package fanp_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_EXPANSION  = 8'h06;
	localparam logic [7:0]  IDX_NP_TX      = 8'h07;
	localparam logic [7:0]  IDX_PARTNER_NP = 8'h08;
	localparam logic [7:0]  IDX_EXT_STATUS = 8'h0f;
	localparam logic [7:0]  IDX_CONTROL    = 8'h10;
	localparam logic [7:0]  IDX_IRQ_STATUS = 8'h11;
	localparam logic [7:0]  IDX_IRQ_MASK   = 8'h12;
	localparam logic [7:0]  IDX_MISC       = 8'h13;

	// Expansion fields
	localparam int          EXP_PARTNER_NP = 3;
	localparam int          EXP_LOCAL_NP   = 2;
	localparam int          EXP_PAGE_RX    = 1;
	localparam int          EXP_PARTNER_AN = 0;

	// Code word fields
	localparam int          CW_NEXT_PAGE   = 15;
	localparam int          CW_TOGGLE      = 11;
	localparam logic [15:0] NP_TX_WMASK    = 16'hb7ff;
	localparam logic [15:0] NP_TX_RESET    = 16'h2001;

	// Control register fields
	localparam int          CTL_AN_EN      = 12;
	localparam logic [15:0] CTL_RESET      = 16'h1000;

	// Interrupt status bits
	localparam int          IRQ_PAGE       = 0;
	localparam int          IRQ_NEXT_PAGE  = 1;
	localparam int          IRQ_LINK_DOWN  = 2;
	localparam int          IRQ_NP_LOADED  = 3;
	localparam int          IRQ_W          = 4;

	localparam int          MATCH_NEEDED   = 3;

	typedef enum logic [1:0] {
		FANP_MODE_100FX   = 2'b00,
		FANP_MODE_1000X   = 2'b01,
		FANP_MODE_SYSTEM  = 2'b10,
		FANP_MODE_MEDIA   = 2'b11
	} fanp_mode_t;

	// Page arriving from the negotiation machine
	typedef struct packed {
		logic        valid;
		logic        is_next;
		logic [15:0] word;
	} fanp_rx_page_t;
endpackage

// >>> fanp_cfg_match.sv
// Counts consecutive identical non-zero configuration code groups
module fanp_cfg_match (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        sync_ok,
	input  wire logic        cfg_valid,
	input  wire logic [15:0] cfg_word,
	output logic             matched_q
);
	logic [15:0] last_q;
	logic [1:0]  count_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_q  <= 16'h0000;
			count_q <= 2'h0;
		end else if (!sync_ok) begin
			count_q <= 2'h0;
		end else if (cfg_valid) begin
			last_q <= cfg_word;
			if (cfg_word == 16'h0000)
				count_q <= 2'h0;
			else if (cfg_word != last_q || count_q == 2'h0)
				count_q <= 2'h1;
			else if (count_q != 2'(fanp_pkg::MATCH_NEEDED))
				count_q <= count_q + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			matched_q <= 1'b0;
		else
			matched_q <= sync_ok && (count_q == 2'(fanp_pkg::MATCH_NEEDED));
	end
endmodule

// >>> fanp_regs.sv
module fanp_regs (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [1:0]            fiber_mode,
	input  wire logic                  link_up,
	input  wire logic                  sync_ok,
	input  wire logic                  cfg_valid,
	input  wire logic [15:0]           cfg_word,
	input  wire fanp_pkg::fanp_rx_page_t rx_page,
	output logic      [15:0]           tx_np_word,
	output logic                       tx_np_active,
	output logic                       np_loaded,
	output logic                       an_enable,
	output logic                       irq
);
	logic [15:0]          np_tx_q;
	logic [15:0]          partner_np_q;
	logic [15:0]          ctl_q;
	logic [fanp_pkg::IRQ_W-1:0] irq_stat_q;
	logic [fanp_pkg::IRQ_W-1:0] irq_mask_q;
	logic                 partner_np_able_q;
	logic                 page_rx_q;
	logic                 link_q;
	logic                 matched;
	logic                 is_1000x;
	logic                 link_down;
	logic                 access;
	logic                 wr;
	logic                 rd;
	logic [15:0]          rd_val;
	logic                 mapped;
	logic [fanp_pkg::IRQ_W-1:0] events;
	logic                 exp_rd;
	logic                 irq_rd;
	logic [fanp_pkg::IRQ_W-1:0] irq_clr;
	logic                 toggle_ref_q;

	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		return (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
	endfunction

	function automatic logic caps_1000x(input logic [1:0] mode);
		return mode != fanp_pkg::FANP_MODE_100FX;
	endfunction

	fanp_cfg_match u_match (
		.pclk      (pclk),
		.presetn   (presetn),
		.sync_ok   (sync_ok),
		.cfg_valid (cfg_valid),
		.cfg_word  (cfg_word),
		.matched_q (matched)
	);

	assign is_1000x  = fiber_mode == fanp_pkg::FANP_MODE_1000X;
	assign link_down = link_q && !link_up;
	assign access    = psel && penable && pready;
	assign wr        = access && pwrite;
	assign rd        = access && !pwrite;
	assign exp_rd    = rd && hit(paddr, fanp_pkg::IDX_EXPANSION);
	assign irq_rd    = rd && hit(paddr, fanp_pkg::IDX_IRQ_STATUS);
	assign irq_clr   = irq_rd ? prdata[fanp_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			link_q <= 1'b0;
		else
			link_q <= link_up;
	end

	// No wait state: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl_q <= fanp_pkg::CTL_RESET;
		else if (wr && hit(paddr, fanp_pkg::IDX_CONTROL))
			ctl_q <= pwdata[15:0] & fanp_pkg::CTL_RESET;
	end
	assign an_enable = ctl_q[fanp_pkg::CTL_AN_EN];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask_q <= '0;
		else if (wr && hit(paddr, fanp_pkg::IDX_IRQ_MASK))
			irq_mask_q <= pwdata[fanp_pkg::IRQ_W-1:0];
	end

	// Transmit page; toggle kept by hardware only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			np_tx_q <= fanp_pkg::NP_TX_RESET;
		end else begin
			if (wr && hit(paddr, fanp_pkg::IDX_NP_TX))
				np_tx_q <= (pwdata[15:0] & fanp_pkg::NP_TX_WMASK)
				         | (np_tx_q & ~fanp_pkg::NP_TX_WMASK);
			if (rx_page.valid)
				np_tx_q[fanp_pkg::CW_TOGGLE] <= ~np_tx_q[fanp_pkg::CW_TOGGLE];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_np_word   <= 16'h0000;
			tx_np_active <= 1'b0;
			np_loaded    <= 1'b0;
		end else begin
			tx_np_word   <= is_1000x ? np_tx_q : 16'h0000;
			tx_np_active <= is_1000x;
			np_loaded    <= wr && hit(paddr, fanp_pkg::IDX_NP_TX) && is_1000x;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			partner_np_q <= 16'h0000;
		else if (link_down)
			partner_np_q <= 16'h0000;
		else if (rx_page.valid && rx_page.is_next && is_1000x)
			partner_np_q <= rx_page.word;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			partner_np_able_q <= 1'b0;
		else if (!is_1000x || link_down)
			partner_np_able_q <= 1'b0;
		else if (rx_page.valid && !rx_page.is_next && rx_page.word[fanp_pkg::CW_NEXT_PAGE])
			partner_np_able_q <= 1'b1;
	end

	// New page wins over the clearing read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			page_rx_q <= 1'b0;
		else if (rx_page.valid)
			page_rx_q <= 1'b1;
		else if (exp_rd && prdata[fanp_pkg::EXP_PAGE_RX])
			page_rx_q <= 1'b0;
	end

	assign events[fanp_pkg::IRQ_PAGE]      = rx_page.valid;
	assign events[fanp_pkg::IRQ_NEXT_PAGE] = rx_page.valid && rx_page.is_next;
	assign events[fanp_pkg::IRQ_LINK_DOWN] = link_down;
	assign events[fanp_pkg::IRQ_NP_LOADED] = wr && hit(paddr, fanp_pkg::IDX_NP_TX);

	// A read clears only the bits it returned; a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~irq_clr) | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_q & irq_mask_q);
	end

	always_comb begin
		rd_val = 16'h0000;
		mapped = 1'b1;
		if (hit(paddr, fanp_pkg::IDX_EXPANSION)) begin
			rd_val[fanp_pkg::EXP_PARTNER_NP] = partner_np_able_q;
			rd_val[fanp_pkg::EXP_LOCAL_NP]   = 1'b1;
			rd_val[fanp_pkg::EXP_PAGE_RX]    = page_rx_q;
			rd_val[fanp_pkg::EXP_PARTNER_AN] = matched && an_enable;
		end else if (hit(paddr, fanp_pkg::IDX_NP_TX)) begin
			rd_val = np_tx_q;
		end else if (hit(paddr, fanp_pkg::IDX_PARTNER_NP)) begin
			rd_val = partner_np_q;
		end else if (hit(paddr, fanp_pkg::IDX_EXT_STATUS)) begin
			rd_val[15] = caps_1000x(fiber_mode);
			rd_val[14] = caps_1000x(fiber_mode);
			rd_val[13:12] = 2'b00;
		end else if (hit(paddr, fanp_pkg::IDX_CONTROL)) begin
			rd_val = ctl_q;
		end else if (hit(paddr, fanp_pkg::IDX_IRQ_STATUS)) begin
			rd_val[fanp_pkg::IRQ_W-1:0] = irq_stat_q;
		end else if (hit(paddr, fanp_pkg::IDX_IRQ_MASK)) begin
			rd_val[fanp_pkg::IRQ_W-1:0] = irq_mask_q;
		end else if (hit(paddr, fanp_pkg::IDX_MISC)) begin
			rd_val[1:0] = fiber_mode;
			rd_val[2]   = link_q;
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
			pslverr <= !mapped;
		end
	end

	a_page_latch: assert property (@(posedge pclk) disable iff (!presetn)
		rx_page.valid |=> page_rx_q) else $error("page flag not set");
	a_partner_clear: assert property (@(posedge pclk) disable iff (!presetn)
		link_down |=> partner_np_q == 16'h0000) else $error("partner page kept");
	a_npable_clear: assert property (@(posedge pclk) disable iff (!presetn)
		link_down |=> !partner_np_able_q) else $error("np able kept");
	a_np_loaded: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && hit(paddr, fanp_pkg::IDX_NP_TX) && is_1000x) |=> np_loaded)
		else $error("no load pulse");
	a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
		rx_page.valid |=> np_tx_q[11] != $past(np_tx_q[11])) else $error("toggle stuck");
	a_base_no_load: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_page.valid && !rx_page.is_next && !link_down) |=> $stable(partner_np_q))
		else $error("base page loaded");
	a_tx_gated: assert property (@(posedge pclk) disable iff (!presetn)
		!is_1000x |=> tx_np_word == 16'h0000) else $error("tx page leaks");
	a_next_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_page.valid && rx_page.is_next && is_1000x && !link_down)
		|=> partner_np_q == $past(rx_page.word)) else $error("page not mirrored");
	a_npable_mode: assert property (@(posedge pclk) disable iff (!presetn)
		!is_1000x |=> !partner_np_able_q) else $error("np able in wrong mode");
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		|(irq_stat_q & irq_mask_q) |=> irq) else $error("irq missing");

	c_next_page: cover property (@(posedge pclk) disable iff (!presetn)
		rx_page.valid && rx_page.is_next && is_1000x);
	c_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
		page_rx_q ##1 rd && hit(paddr, fanp_pkg::IDX_EXPANSION));
	c_link_drop: cover property (@(posedge pclk) disable iff (!presetn)
		partner_np_q != 16'h0000 ##1 link_down);
	c_an_able: cover property (@(posedge pclk) disable iff (!presetn)
		matched && an_enable);
	c_tx_loaded: cover property (@(posedge pclk) disable iff (!presetn)
		np_loaded);

	// Bus: ready in the first access cycle, error only off the map
	a_bus_ready: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held");
	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !mapped |=> pslverr)
		else $error("no error for unmapped word");

	// Read words as returned to software
	a_local_np: assert property (@(posedge pclk) disable iff (!presetn)
		exp_rd |-> prdata[fanp_pkg::EXP_LOCAL_NP])
		else $error("local next page bit low");
	a_exp_upper: assert property (@(posedge pclk) disable iff (!presetn)
		exp_rd |-> prdata[31:4] == 28'h0000000)
		else $error("expansion upper bits set");
	a_ext_low: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit(paddr, fanp_pkg::IDX_EXT_STATUS)
		|-> prdata[13:12] == 2'b00)
		else $error("1000T capability set");
	a_ext_caps: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit(paddr, fanp_pkg::IDX_EXT_STATUS)
		|-> prdata[15:14] == (($past(fiber_mode) == fanp_pkg::FANP_MODE_100FX) ? 2'b00 : 2'b11))
		else $error("1000X capability wrong");
	a_page_clear: assert property (@(posedge pclk) disable iff (!presetn)
		exp_rd && prdata[fanp_pkg::EXP_PAGE_RX] && !rx_page.valid |=> !page_rx_q)
		else $error("page flag survives read");
	a_an_gate: assert property (@(posedge pclk) disable iff (!presetn)
		exp_rd && !$past(an_enable) |-> !prdata[fanp_pkg::EXP_PARTNER_AN])
		else $error("ability shown while disabled");
	a_tx_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit(paddr, fanp_pkg::IDX_NP_TX)
		|-> prdata[15:0] == $past(np_tx_q))
		else $error("transmit page misread");
	a_pnp_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit(paddr, fanp_pkg::IDX_PARTNER_NP)
		|-> prdata[15:0] == $past(partner_np_q))
		else $error("partner page misread");
	a_misc_mode: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit(paddr, fanp_pkg::IDX_MISC)
		|-> prdata[1:0] == $past(fiber_mode))
		else $error("mode misread");

	// Transmit side and partner register follow the mode; a match needs sync
	a_tx_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		is_1000x |=> tx_np_word == $past(np_tx_q))
		else $error("transmit word differs");
	a_tx_active: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> tx_np_active == $past(is_1000x))
		else $error("active flag wrong");
	a_np_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!is_1000x |=> !np_loaded)
		else $error("load pulse outside 1000X");
	a_pnp_mode: assert property (@(posedge pclk) disable iff (!presetn)
		!is_1000x && !link_down |=> $stable(partner_np_q))
		else $error("partner page moved outside 1000X");
	a_npable_set: assert property (@(posedge pclk) disable iff (!presetn)
		is_1000x && !link_down && rx_page.valid && !rx_page.is_next
		&& rx_page.word[fanp_pkg::CW_NEXT_PAGE] |=> partner_np_able_q)
		else $error("np able not set");
	a_match_sync: assert property (@(posedge pclk) disable iff (!presetn)
		matched |-> $past(sync_ok))
		else $error("match without sync");

	// Reference toggle: flips on every received page, nothing else moves it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			toggle_ref_q <= 1'b0;
		else if (rx_page.valid)
			toggle_ref_q <= ~toggle_ref_q;
	end

	// Sticky events, interrupt level and toggle
	a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		events[fanp_pkg::IRQ_PAGE] |=> irq_stat_q[fanp_pkg::IRQ_PAGE])
		else $error("page event lost");
	a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!(|(irq_stat_q & irq_mask_q)) |=> !irq)
		else $error("irq without cause");
	a_toggle_ref: assert property (@(posedge pclk) disable iff (!presetn)
		np_tx_q[fanp_pkg::CW_TOGGLE] == toggle_ref_q)
		else $error("toggle differs from page count");
endmodule

// >>> fanp_partner.sv
// Remote serial-link partner: link state, sync, code groups and pages
module fanp_partner (
	input  wire logic               pclk,
	output logic                    link_up,
	output logic                    sync_ok,
	output logic                    cfg_valid,
	output logic [15:0]             cfg_word,
	output fanp_pkg::fanp_rx_page_t rx_page
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		link_up = 1'b1;
		sync_ok = 1'b0;
		cfg_valid = 1'b0;
		cfg_word = 16'h0000;
		rx_page = '0;
	end
	// Released words show the inverse so no stale value looks valid
	task automatic send_page(input logic nxt, input logic [15:0] w);
		@(posedge pclk);
		rx_page <= '{valid: 1'b1, is_next: nxt, word: w};
		@(posedge pclk);
		rx_page <= '{valid: 1'b0, is_next: 1'b0, word: ~w};
	endtask
	task automatic send_cfg(input logic [15:0] w, input int n);
		@(posedge pclk);
		sync_ok <= 1'b1;
		repeat (n) begin
			@(posedge pclk);
			cfg_valid <= 1'b1;
			cfg_word <= w;
		end
		@(posedge pclk);
		cfg_valid <= 1'b0;
		cfg_word <= ~w;
	endtask
	task automatic set_link(input logic up);
		@(posedge pclk);
		link_up <= up;
	endtask
endmodule

// >>> fanp_regs_bench.sv
module fanp_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] A_EXP = {2'b00, fanp_pkg::IDX_EXPANSION, 2'b00};
	localparam logic [11:0] A_TX  = {2'b00, fanp_pkg::IDX_NP_TX, 2'b00};
	localparam logic [11:0] A_PNP = {2'b00, fanp_pkg::IDX_PARTNER_NP, 2'b00};
	localparam logic [11:0] A_EXT = {2'b00, fanp_pkg::IDX_EXT_STATUS, 2'b00};
	localparam logic [11:0] A_CTL = {2'b00, fanp_pkg::IDX_CONTROL, 2'b00};
	localparam logic [11:0] A_IRQ = {2'b00, fanp_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [11:0] A_MSK = {2'b00, fanp_pkg::IDX_IRQ_MASK, 2'b00};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  fiber_mode = fanp_pkg::FANP_MODE_1000X;
	logic        link_up;
	logic        sync_ok;
	logic        cfg_valid;
	logic [15:0] cfg_word;
	logic [15:0] tx_np_word;
	logic        tx_np_active;
	logic        np_loaded;
	logic        an_enable;
	logic        irq;
	logic        err;
	int          fail_count = 0;
	int          n_checks = 0;
	fanp_pkg::fanp_rx_page_t rx_page;

	always #25 pclk = ~pclk;

	fanp_regs fanp_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fiber_mode(fiber_mode), .link_up(link_up), .sync_ok(sync_ok),
		.cfg_valid(cfg_valid), .cfg_word(cfg_word), .rx_page(rx_page),
		.tx_np_word(tx_np_word), .tx_np_active(tx_np_active), .np_loaded(np_loaded),
		.an_enable(an_enable), .irq(irq));
	fanp_partner fanp_partner_inst (.pclk(pclk), .link_up(link_up), .sync_ok(sync_ok),
		.cfg_valid(cfg_valid), .cfg_word(cfg_word), .rx_page(rx_page));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) check(1'b0, 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		check(r, exp);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#(50 * 4000);
		fail_count++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_EXP, 32'h4);
		rd(A_TX, 32'h2001);
		rd(A_PNP, 32'h0);
		rd(A_CTL, 32'h1000);
		check(err, 1'b0);
		rd(12'h100, 32'h0);
		check(err, 1'b1);
		$display("reset values done");
		for (int m = 0; m < 4; m++) begin
			@(posedge pclk);
			fiber_mode <= m[1:0];
			rd(A_EXT, (m == 0) ? 32'h0 : 32'hc000);
		end
		fiber_mode <= fanp_pkg::FANP_MODE_1000X;
		$display("mode capability done");
		wr(A_TX, 32'hffff);
		@(negedge pclk);
		check(np_loaded, 1'b1);
		rd(A_TX, 32'hb7ff);
		check({tx_np_active, tx_np_word}, 17'h1b7ff);
		fiber_mode <= fanp_pkg::FANP_MODE_100FX;
		settle(2);
		check({tx_np_active, tx_np_word}, 17'h0);
		@(posedge pclk);
		fiber_mode <= fanp_pkg::FANP_MODE_1000X;
		$display("transmit page done");
		fanp_partner_inst.send_page(1'b0, 16'h8000);
		rd(A_EXP, 32'he);
		rd(A_EXP, 32'hc);
		rd(A_PNP, 32'h0);
		rd(A_TX, 32'hbfff);
		fanp_partner_inst.send_page(1'b1, 16'h5a5a);
		rd(A_PNP, 32'h5a5a);
		rd(A_TX, 32'hb7ff);
		fanp_partner_inst.set_link(1'b0);
		settle(3);
		rd(A_PNP, 32'h0);
		rd(A_EXP, 32'h6);
		fanp_partner_inst.set_link(1'b1);
		rd(A_IRQ, 32'hf);
		rd(A_IRQ, 32'h0);
		rd({2'b00, fanp_pkg::IDX_MISC, 2'b00}, 32'h5);
		check(err, 1'b0);
		$display("pages and link done");
		wr(A_MSK, 32'h0);
		fanp_partner_inst.send_page(1'b0, 16'h0000);
		settle(3);
		check(irq, 1'b0);
		wr(A_MSK, 32'hf);
		settle(3);
		check(irq, 1'b1);
		rd(A_IRQ, 32'h1);
		settle(3);
		check(irq, 1'b0);
		$display("interrupt done");
		@(posedge pclk);
		fiber_mode <= fanp_pkg::FANP_MODE_100FX;
		fanp_partner_inst.send_page(1'b0, 16'h8000);
		fanp_partner_inst.send_page(1'b1, 16'h1234);
		rd(A_EXP, 32'h6);
		rd(A_PNP, 32'h0);
		fiber_mode <= fanp_pkg::FANP_MODE_1000X;
		$display("other mode done");
		fanp_partner_inst.send_cfg(16'h4020, 2);
		rd(A_EXP, 32'h4);
		fanp_partner_inst.send_cfg(16'h4020, 3);
		settle(2);
		rd(A_EXP, 32'h5);
		wr(A_CTL, 32'h0);
		rd(A_EXP, 32'h4);
		check(an_enable, 1'b0);
		$display("negotiation ability done");
		report_and_stop();
	end
endmodule
